// File: core/crg_guard.sv
/*
  crg_guard: reset latch, program counter start and vectoring, stack pointers,
  interrupt gate, prefix flag, memory window decode and reset pin state.
  Assumes the core sequencer drives one-cycle strobes synchronous to mclk and
  a slow divided tick from the low-speed oscillator arrives as a level.
*/
`timescale 1ns/1ps
// How it works
// (RULE_01) reset release loads start address, fetch begins
// (RULE_02) reset clears interrupt and extension flags
// (RULE_03) interrupts incl. nmi blocked until both pointers
// (RULE_04) rewriting one pointer re-masks until other rewritten
// (RULE_05) prefix write sets flag for next instruction
// (RULE_06) output pins high, shared functions deselected
// (RULE_07) io pins input, pull-up per build option
// (RULE_08) nmi and hardware sources use fixed vectors
// (RULE_09) code memory 13-bit words up to top
// (RULE_10) data ram decoded up to its top
// (RULE_11) only window allows wide access
// (RULE_12) stack pointers wrap within their ranges
// (RULE_13) only wide stack operations are 16-bit
// (RULE_14) call pushes pc as four wide words
// (RULE_15) interrupt pushes pc four, flags one
// (RULE_16) halt opcode unsupported, flagged and ignored
// (RULE_17) reset latch released by slow tick high
// (RULE_18) two written indicators, each clears other
module crg_guard #(
  parameter int R_PINS = 12,
  parameter int P_PINS = 16,
  parameter bit PULLUP_OPT = 1'b1,
  parameter int SRC_W = 3
) (
  input wire logic mclk, // 100 MHz system clock
  input wire logic rst_b, // external reset, active low
  input wire logic slow_tick, // 2 Hz divided clock level
  input wire logic step_done, // current instruction finished
  input wire logic [15:0] next_pc, // pc for the following step
  input wire logic call_req, // subroutine call strobe
  input wire logic [15:0] call_target, // call destination
  input wire logic wide_sp_wr, // write of wide stack pointer
  input wire logic [9:0] wide_sp_d, // new wide pointer
  input wire logic nibble_sp_wr, // write of nibble stack pointer
  input wire logic [7:0] nibble_sp_d, // new nibble pointer
  input wire logic prefix_wr, // write of the prefix register
  input wire logic [7:0] prefix_d, // prefix value
  input wire logic int_en_set, // enable interrupts
  input wire logic int_en_clr, // disable interrupts
  input wire logic halt_opcode, // halt opcode decoded
  input wire logic nmi_req, // non-maskable request level
  input wire logic irq_req, // maskable request level
  input wire logic [SRC_W-1:0] irq_src, // hardware source index
  input wire logic [15:0] data_addr, // data memory address
  input wire logic data_acc, // data access strobe
  input wire logic data_wide, // access is 16-bit
  input wire logic data_stack, // access made through wide pointer
  input wire logic [R_PINS-1:0] r_out_d, // output port data
  input wire logic r_out_wr, // output port write
  input wire logic [R_PINS-1:0] r_func_d, // special function select
  input wire logic r_func_wr, // special function write
  input wire logic [P_PINS-1:0] p_out_d, // io port data
  input wire logic [P_PINS-1:0] p_dir_d, // io port direction, 1 = out
  input wire logic p_wr, // io port data and direction write
  output logic init_rst, // internal initial reset
  output logic [15:0] pc_q, // program counter / fetch address
  output logic fetch_en, // fetching allowed
  output logic rom_sel, // fetch inside code memory
  output logic int_flag_q, // interrupt enable flag
  output logic ext_flag_q, // extended addressing flag
  output logic [7:0] prefix_q, // held prefix value
  output logic [9:0] wide_sp_q, // wide stack pointer
  output logic [7:0] nibble_sp_q, // nibble stack pointer
  output logic int_gate, // interrupts may pass
  output logic int_take, // interrupt entry pulse
  output logic nmi_take, // entry was the nmi
  output logic push_wide, // wide stack push strobe
  output logic [9:0] push_wide_addr_q, // base of four wide words
  output logic [15:0] push_pc_q, // pc saved on the wide stack
  output logic push_flag, // flag push strobe
  output logic [7:0] push_flag_addr_q, // nibble stack slot
  output logic ram_sel, // data address hits ram
  output logic wide_ok, // data address allows wide access
  output logic acc_fault, // wide access not through the wide pointer or outside the window
  output logic halt_bad_q, // halt opcode was seen
  output logic [R_PINS-1:0] r_pin_q, // output port levels
  output logic [R_PINS-1:0] r_func_q, // special function selected
  output logic [P_PINS-1:0] p_out_q, // io output level
  output logic [P_PINS-1:0] p_oe_q, // io output enable
  output logic [P_PINS-1:0] p_pullup // io pull-up enable
);
  crg_pkg::crg_state_t st_q;
  logic hold_q;
  logic clr;
  logic wide_set_q;
  logic nibble_set_q;
  logic ext_armed_q;
  logic take;
  logic [15:0] hw_vec;
  logic [15:0] vec;

  initial begin
    if (SRC_W < 1 || SRC_W > 3) $error("source index width unsupported");
    if (R_PINS < 1 || P_PINS < 1) $error("pin counts must be positive");
  end

  // reset latch: held from rst_b low until the slow tick reads high
  always_ff @(posedge mclk) begin
    if (!rst_b) hold_q <= 1'b1; // RULE_17
    else if (slow_tick) hold_q <= 1'b0; // RULE_17
  end
  assign init_rst = hold_q;
  assign clr = !rst_b || hold_q;

  // run state: the hold cycle after release loads the start address once
  always_ff @(posedge mclk) begin
    if (clr) st_q <= crg_pkg::CRG_HOLD;
    else begin
      case (st_q)
        crg_pkg::CRG_HOLD: st_q <= crg_pkg::CRG_START;
        crg_pkg::CRG_START: st_q <= crg_pkg::CRG_RUN;
        crg_pkg::CRG_RUN: st_q <= crg_pkg::CRG_RUN;
        default: st_q <= crg_pkg::CRG_HOLD;
      endcase
    end
  end
  assign fetch_en = (st_q == crg_pkg::CRG_RUN); // RULE_01

  // written-since-reset indicators; a rewrite while both are set clears the
  // other one, so the first pair after reset only fills them in
  // clearing on every write would keep the gate shut for any pair written
  // one after the other, which is the normal start-up order of software
  always_ff @(posedge mclk) begin
    if (clr) begin
      wide_set_q <= 1'b0; // RULE_03
      nibble_set_q <= 1'b0;
    end else begin
      if (wide_sp_wr) wide_set_q <= 1'b1; // RULE_18
      else if (nibble_sp_wr && int_gate) wide_set_q <= 1'b0; // RULE_04
      if (nibble_sp_wr) nibble_set_q <= 1'b1; // RULE_18
      else if (wide_sp_wr && int_gate) nibble_set_q <= 1'b0; // RULE_04
    end
  end
  assign int_gate = wide_set_q && nibble_set_q; // RULE_03

  // vectors: nmi first, hardware sources two steps apart, clamped to range
  always_comb begin
    hw_vec = crg_pkg::HW_VEC_FIRST + {{(15 - SRC_W){1'b0}}, irq_src, 1'b0};
    if (hw_vec > crg_pkg::HW_VEC_LAST) hw_vec = crg_pkg::HW_VEC_LAST; // RULE_08
    vec = nmi_req ? crg_pkg::NMI_VECTOR : hw_vec; // RULE_08
  end
  // entry only at an instruction boundary, never inside a prefixed pair
  assign take = fetch_en && step_done && int_gate && !ext_armed_q && !ext_flag_q
                && (nmi_req || (irq_req && int_flag_q)); // RULE_03
  assign int_take = take;
  assign nmi_take = take && nmi_req;

  // program counter: start address after release, then steps and jumps
  always_ff @(posedge mclk) begin
    if (clr || st_q == crg_pkg::CRG_HOLD) pc_q <= crg_pkg::START_ADDR; // RULE_01
    else if (take) pc_q <= vec; // RULE_08
    else if (fetch_en && call_req) pc_q <= call_target;
    else if (fetch_en && step_done) pc_q <= next_pc;
  end
  assign rom_sel = (pc_q <= crg_pkg::CODE_TOP); // RULE_09

  // interrupt flag: cleared by reset and by entry, set wins over clear
  always_ff @(posedge mclk) begin
    if (clr) int_flag_q <= crg_pkg::INT_FLAG_RST; // RULE_02
    else if (int_en_set) int_flag_q <= 1'b1;
    else if (int_en_clr || take) int_flag_q <= 1'b0;
  end

  // prefix flag: armed by the write, covers exactly the next instruction
  always_ff @(posedge mclk) begin
    if (clr) begin
      ext_flag_q <= crg_pkg::EXT_FLAG_RST; // RULE_02
      ext_armed_q <= 1'b0;
    end else if (prefix_wr) begin
      ext_flag_q <= 1'b1; // RULE_05
      ext_armed_q <= 1'b1;
    end else if (step_done) begin
      ext_armed_q <= 1'b0;
      ext_flag_q <= ext_armed_q; // RULE_05
    end
  end
  // prefix content is not cleared by reset; software sets it when used
  always_ff @(posedge mclk) begin
    if (prefix_wr) prefix_q <= prefix_d;
  end

  // stack pointers: 10 and 8 bits wide, so subtraction wraps in range
  always_ff @(posedge mclk) begin
    if (wide_sp_wr) wide_sp_q <= wide_sp_d & crg_pkg::WIDE_SP_TOP; // RULE_12
    else if (take || (fetch_en && call_req)) wide_sp_q <= wide_sp_q - crg_pkg::CALL_WORDS; // RULE_14
    if (nibble_sp_wr) nibble_sp_q <= nibble_sp_d & crg_pkg::NIBBLE_SP_TOP; // RULE_12
    else if (take) nibble_sp_q <= nibble_sp_q - crg_pkg::FLAG_WORDS; // RULE_15
  end

  // push strobes: one cycle after the entry or call, data from flops
  always_ff @(posedge mclk) begin
    if (clr) begin
      push_wide <= 1'b0;
      push_flag <= 1'b0;
      push_wide_addr_q <= 10'h000;
      push_flag_addr_q <= 8'h00;
      push_pc_q <= 16'h0000;
    end else begin
      push_wide <= take || (fetch_en && call_req); // RULE_14
      push_flag <= take; // RULE_15
      if (take || (fetch_en && call_req)) begin
        push_wide_addr_q <= wide_sp_q - crg_pkg::CALL_WORDS; // RULE_15
        push_pc_q <= take ? next_pc : next_pc;
      end
      if (take) push_flag_addr_q <= nibble_sp_q - crg_pkg::FLAG_WORDS; // RULE_15
    end
  end

  // data decode; wide access only through the wide pointer inside the window
  assign ram_sel = (data_addr <= crg_pkg::RAM_TOP); // RULE_10
  assign wide_ok = (data_addr >= crg_pkg::WIDE_WIN_LO)
                   && (data_addr <= crg_pkg::WIDE_WIN_HI); // RULE_11
  assign acc_fault = data_acc && data_wide && (!data_stack || !wide_ok); // RULE_13

  // halt opcode has no sleep mode behind it; it is only recorded
  always_ff @(posedge mclk) begin
    if (clr) halt_bad_q <= 1'b0;
    else if (halt_opcode) halt_bad_q <= 1'b1; // RULE_16
  end

  // shared terminals: general purpose at reset, per-pin updates
  for (genvar i = 0; i < R_PINS; i++) begin : g_rpin
    always_ff @(posedge mclk) begin
      if (clr) begin
        r_pin_q[i] <= crg_pkg::R_PIN_RST; // RULE_06
        r_func_q[i] <= 1'b0; // RULE_06
      end else begin
        if (r_out_wr) r_pin_q[i] <= r_out_d[i];
        if (r_func_wr) r_func_q[i] <= r_func_d[i];
      end
    end
  end
  for (genvar j = 0; j < P_PINS; j++) begin : g_ppin
    always_ff @(posedge mclk) begin
      if (clr) begin
        p_oe_q[j] <= 1'b0; // RULE_07
        p_out_q[j] <= 1'b0; // RULE_06
      end else if (p_wr) begin
        p_oe_q[j] <= p_dir_d[j];
        p_out_q[j] <= p_out_d[j];
      end
    end
    // pull-up only while the pin is an input and the option has it
    assign p_pullup[j] = PULLUP_OPT && !p_oe_q[j]; // RULE_07
  end

  // checks
  latch_hold_a: assert property (@(posedge mclk) !rst_b |=> init_rst) // RULE_17
    else $error("reset latch not held");
  latch_free_a: assert property (@(posedge mclk) rst_b && init_rst && slow_tick |=> !init_rst)
    else $error("reset latch not released by tick"); // RULE_17
  start_pc_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(init_rst) |-> ##1 (pc_q == crg_pkg::START_ADDR) ##1 fetch_en) // RULE_01
    else $error("start address not loaded");
  flags_rst_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(init_rst) |-> !int_flag_q && !ext_flag_q) // RULE_02
    else $error("flags not cleared by reset");
  gate_block_a: assert property (@(posedge mclk) disable iff (clr)
    int_take |-> wide_set_q && nibble_set_q) // RULE_03
    else $error("interrupt taken without both pointers");
  remask_a: assert property (@(posedge mclk) disable iff (clr)
    int_gate && wide_sp_wr && !nibble_sp_wr |=> !int_gate) // RULE_04
    else $error("gate not re-masked");
  ext_next_a: assert property (@(posedge mclk) disable iff (clr)
    prefix_wr |=> ext_flag_q until_with step_done) // RULE_05
    else $error("prefix flag lost early");
  nmi_vec_a: assert property (@(posedge mclk) disable iff (clr)
    nmi_take |=> pc_q == crg_pkg::NMI_VECTOR) // RULE_08
    else $error("nmi vector wrong");
  wide_push_a: assert property (@(posedge mclk) disable iff (clr)
    int_take |=> push_wide && push_flag
    && wide_sp_q == $past(wide_sp_q) - crg_pkg::CALL_WORDS) // RULE_15
    else $error("interrupt push wrong");
  width_a: assert property (@(posedge mclk)
    data_acc && data_wide && data_stack && data_addr == crg_pkg::WIDE_WIN_HI
    |-> !acc_fault) // RULE_11
    else $error("wide window rejected");
  pins_rst_a: assert property (@(posedge mclk) !rst_b |=> &r_pin_q && ~|p_oe_q) // RULE_06
    else $error("pins not reset");
  // reset side: these run without disable so that the clear itself is seen
  pc_start_a: assert property (@(posedge mclk) clr |=> pc_q == crg_pkg::START_ADDR) // RULE_01
    else $error("pc not at start during clear");
  fetch_hold_a: assert property (@(posedge mclk) clr |=> !fetch_en) // RULE_01
    else $error("fetch allowed during clear");
  func_rst_a: assert property (@(posedge mclk) !rst_b |=> ~|r_func_q) // RULE_06
    else $error("special functions not deselected");
  // gate: a pair written in one cycle opens it at once
  gate_open_a: assert property (@(posedge mclk) disable iff (clr)
    wide_sp_wr && nibble_sp_wr |=> int_gate) // RULE_18
    else $error("gate shut after pair write");
  // entry side effects; pointer writes in the same cycle would move the base
  flag_push_a: assert property (@(posedge mclk) disable iff (clr)
    int_take && !nibble_sp_wr |=> nibble_sp_q == $past(nibble_sp_q) - crg_pkg::FLAG_WORDS
    && push_flag_addr_q == nibble_sp_q) // RULE_15
    else $error("flag push wrong");
  int_clear_a: assert property (@(posedge mclk) disable iff (clr)
    int_take && !int_en_set |=> !int_flag_q) // RULE_15
    else $error("interrupt flag kept on entry");
  vec_range_a: assert property (@(posedge mclk) disable iff (clr)
    int_take && !nmi_take |=> pc_q >= crg_pkg::HW_VEC_FIRST
    && pc_q <= crg_pkg::HW_VEC_LAST) // RULE_08
    else $error("hardware vector out of range");
  call_push_a: assert property (@(posedge mclk) disable iff (clr)
    fetch_en && call_req && !int_take && !wide_sp_wr |=> push_wide && !push_flag
    && pc_q == $past(call_target) && push_wide_addr_q == wide_sp_q) // RULE_14
    else $error("call push wrong");
  // prefix covers one instruction only
  ext_clear_a: assert property (@(posedge mclk) disable iff (clr)
    step_done && !ext_armed_q && !prefix_wr |=> !ext_flag_q) // RULE_05
    else $error("prefix flag outlived its instruction");
  halt_seen_a: assert property (@(posedge mclk) disable iff (clr)
    halt_opcode |=> halt_bad_q) // RULE_16
    else $error("halt opcode not recorded");
  // decode side
  rom_range_a: assert property (@(posedge mclk) pc_q > crg_pkg::CODE_TOP |-> !rom_sel) // RULE_09
    else $error("fetch beyond code memory selected");
  ram_range_a: assert property (@(posedge mclk)
    data_addr > crg_pkg::RAM_TOP |-> !ram_sel && !wide_ok) // RULE_10
    else $error("ram selected beyond its top");
  narrow_ok_a: assert property (@(posedge mclk) data_acc && !data_wide |-> !acc_fault) // RULE_13
    else $error("nibble access faulted");
  pullup_a: assert property (@(posedge mclk) ~|(p_pullup & p_oe_q)) // RULE_07
    else $error("pull-up on a driven pin");
  // main scenarios
  nmi_entry_c: cover property (@(posedge mclk) disable iff (clr) nmi_take);
  irq_entry_c: cover property (@(posedge mclk) disable iff (clr) int_take && !nmi_take);
  prefix_c: cover property (@(posedge mclk) disable iff (clr) prefix_wr ##1 ext_flag_q);
  remask_c: cover property (@(posedge mclk) disable iff (clr) int_gate ##1 !int_gate);
  call_c: cover property (@(posedge mclk) disable iff (clr) fetch_en && call_req);
endmodule

// File: core/crg_pkg.sv
/*
  crg_pkg: constants shared by the reset and stack guard of the 4-bit core.
  Assumes a single 100 MHz clock domain and no software-visible registers.
*/
package crg_pkg;
  // program memory map
  localparam logic [15:0] START_ADDR = 16'h0110;
  localparam logic [15:0] NMI_VECTOR = 16'h0100;
  localparam logic [15:0] HW_VEC_FIRST = 16'h0104;
  localparam logic [15:0] HW_VEC_LAST = 16'h010E;
  localparam logic [15:0] CODE_TOP = 16'h3FFF;
  localparam int CODE_WORD_W = 13;
  // data memory map
  localparam logic [15:0] RAM_TOP = 16'h13FF;
  localparam logic [15:0] WIDE_WIN_LO = 16'h0100;
  localparam logic [15:0] WIDE_WIN_HI = 16'h01FF;
  // stack pointer ranges and usage
  localparam logic [9:0] WIDE_SP_TOP = 10'h3FF;
  localparam logic [7:0] NIBBLE_SP_TOP = 8'hFF;
  localparam logic [9:0] CALL_WORDS = 10'h004;
  localparam logic [7:0] FLAG_WORDS = 8'h01;
  // reset values
  localparam logic INT_FLAG_RST = 1'b0;
  localparam logic EXT_FLAG_RST = 1'b0;
  localparam logic R_PIN_RST = 1'b1;
  // run state of the core
  typedef enum logic [1:0] {
    CRG_HOLD = 2'b00,
    CRG_START = 2'b01,
    CRG_RUN = 2'b10
  } crg_state_t;
endpackage

// File: tb/crg_guard_tb.sv
/*
  crg_guard_tb: self-checking bench for the reset and stack guard.
  Assumes the default parameters of crg_guard and a single 100 MHz mclk.
*/
`timescale 1ns/1ps
module crg_guard_tb;
  localparam int RP = 12;
  localparam int PP = 16;
  typedef struct packed {logic [15:0] addr; logic [1:0] ctl; logic [2:0] exp;} crg_dec_row_t;
  // ctl = {wide, stack}, exp = {ram_sel, wide_ok, acc_fault}
  localparam crg_dec_row_t ROWS [8] = '{'{16'h0000, 2'h0, 3'h4}, '{16'h0100, 2'h3, 3'h6},
    '{16'h01FF, 2'h3, 3'h6}, '{16'h00FF, 2'h3, 3'h5}, '{16'h0200, 2'h3, 3'h5},
    '{16'h0150, 2'h2, 3'h7}, '{16'h13FF, 2'h0, 3'h4}, '{16'h1400, 2'h0, 3'h0}};
  logic mclk, rst_b, slow_tick, step_done, call_req, wide_sp_wr, nibble_sp_wr, prefix_wr;
  logic int_en_set, int_en_clr, halt_opcode, nmi_req, irq_req, data_acc, data_wide, data_stack;
  logic r_out_wr, r_func_wr, p_wr;
  logic [15:0] next_pc, call_target, data_addr, push_pc_q, pc_q;
  logic [9:0] wide_sp_d, wide_sp_q, push_wide_addr_q, exp_wsp;
  logic [7:0] nibble_sp_d, prefix_d, prefix_q, nibble_sp_q, push_flag_addr_q;
  logic [2:0] irq_src;
  logic [RP-1:0] r_out_d, r_func_d, r_pin_q, r_func_q;
  logic [PP-1:0] p_out_d, p_dir_d, p_out_q, p_oe_q, p_pullup;
  logic init_rst, fetch_en, rom_sel, int_flag_q, ext_flag_q, int_gate, int_take, nmi_take;
  logic push_wide, push_flag, ram_sel, wide_ok, acc_fault, halt_bad_q;
  int err_total, checks_done;

  crg_guard i_crg_guard (.mclk(mclk), .rst_b(rst_b), .slow_tick(slow_tick),
    .step_done(step_done), .next_pc(next_pc), .call_req(call_req), .call_target(call_target),
    .wide_sp_wr(wide_sp_wr), .wide_sp_d(wide_sp_d), .nibble_sp_wr(nibble_sp_wr),
    .nibble_sp_d(nibble_sp_d), .prefix_wr(prefix_wr), .prefix_d(prefix_d),
    .int_en_set(int_en_set), .int_en_clr(int_en_clr), .halt_opcode(halt_opcode),
    .nmi_req(nmi_req), .irq_req(irq_req), .irq_src(irq_src), .data_addr(data_addr),
    .data_acc(data_acc), .data_wide(data_wide), .data_stack(data_stack), .r_out_d(r_out_d),
    .r_out_wr(r_out_wr), .r_func_d(r_func_d), .r_func_wr(r_func_wr), .p_out_d(p_out_d),
    .p_dir_d(p_dir_d), .p_wr(p_wr), .init_rst(init_rst), .pc_q(pc_q), .fetch_en(fetch_en),
    .rom_sel(rom_sel), .int_flag_q(int_flag_q), .ext_flag_q(ext_flag_q), .prefix_q(prefix_q),
    .wide_sp_q(wide_sp_q), .nibble_sp_q(nibble_sp_q), .int_gate(int_gate),
    .int_take(int_take), .nmi_take(nmi_take), .push_wide(push_wide),
    .push_wide_addr_q(push_wide_addr_q), .push_pc_q(push_pc_q), .push_flag(push_flag),
    .push_flag_addr_q(push_flag_addr_q), .ram_sel(ram_sel), .wide_ok(wide_ok),
    .acc_fault(acc_fault), .halt_bad_q(halt_bad_q), .r_pin_q(r_pin_q), .r_func_q(r_func_q),
    .p_out_q(p_out_q), .p_oe_q(p_oe_q), .p_pullup(p_pullup));

  // free-running system clock
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // bounded wait; a hang here ends the run with a mismatch
  task automatic wait_fetch;
    int n;
    n = 0;
    while (fetch_en !== 1'h1 && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 40) begin
      err_total++;
      $display("[FAIL] fetch_en expected 1 seen %b", fetch_en);
      wrap_up();
    end
  endtask

  // pointer writes are one-cycle strobes; gate answers on the following cycle
  task automatic sp_wr(input logic w, input logic n, input logic [15:0] exp_gate);
    @(posedge mclk);
    wide_sp_wr <= w;
    nibble_sp_wr <= n;
    @(posedge mclk);
    wide_sp_wr <= 1'h0;
    nibble_sp_wr <= 1'h0;
    #1 chk("int_gate", int_gate, exp_gate);
  endtask

  // entry is requested together with an instruction end, levels dropped after
  task automatic take_int(input logic nmi, input logic [2:0] src, input logic [15:0] npc);
    @(posedge mclk);
    nmi_req <= nmi;
    irq_req <= ~nmi;
    irq_src <= src;
    step_done <= 1'h1;
    next_pc <= npc;
    #1 chk("take", {int_take, nmi_take}, {14'h0, 1'h1, nmi});
    @(posedge mclk);
    {nmi_req, irq_req, step_done} <= 3'h0;
    exp_wsp = exp_wsp - 10'h004;
    #1 chk("wide_sp", wide_sp_q, exp_wsp);
    chk("pushes", {push_wide, push_flag, int_flag_q}, 16'h6);
    chk("push_pc", push_pc_q, npc);
  endtask

  // main sequence: reset, decode table, then the awkward cases
  initial begin
    {step_done, call_req, wide_sp_wr, nibble_sp_wr, prefix_wr, int_en_set, int_en_clr} = 7'h0;
    {halt_opcode, nmi_req, irq_req, data_acc, data_wide, data_stack, r_out_wr} = 7'h0;
    {r_func_wr, p_wr, rst_b, slow_tick, irq_src} = 7'h0;
    {next_pc, call_target, data_addr, wide_sp_d, nibble_sp_d, prefix_d} = 74'h0;
    {r_out_d, r_func_d, p_out_d, p_dir_d} = 56'h0;
    err_total = 0;
    checks_done = 0;
    for (int c = 0; c < 2; c++) begin
      repeat (12) @(posedge mclk);
      #1 chk("pc", pc_q, crg_pkg::START_ADDR);
      chk("flags", {int_flag_q, ext_flag_q, int_gate}, 16'h0);
      chk("r_pins", {r_pin_q, r_func_q}, 24'hFFF000);
      chk("p_pins", {p_oe_q, p_pullup}, 32'h0000FFFF);
      @(posedge mclk);
      rst_b <= 1'h1;
      repeat (4) @(posedge mclk);
      #1 chk("init_rst", init_rst, 16'h1);
      @(posedge mclk);
      slow_tick <= 1'h1;
      wait_fetch();
      chk("pc", pc_q, crg_pkg::START_ADDR);
      if (c == 0) begin
        slow_tick <= 1'h0;
        foreach (ROWS[i]) begin
          @(posedge mclk);
          {data_acc, data_wide, data_stack} <= {1'h1, ROWS[i].ctl};
          data_addr <= ROWS[i].addr;
          #1 chk("decode", {ram_sel, wide_ok, acc_fault}, ROWS[i].exp);
        end
        $display("test reset and decode done");
        wide_sp_d <= 10'h002;
        nibble_sp_d <= 8'h00;
        take_int_blocked();
        sp_wr(1'h1, 1'h0, 16'h0);
        sp_wr(1'h0, 1'h1, 16'h1);
        sp_wr(1'h1, 1'h0, 16'h0);
        take_int_blocked();
        sp_wr(1'h0, 1'h1, 16'h1);
        exp_wsp = 10'h002;
        take_int(1'h1, 3'h0, 16'h0123);
        chk("nmi pc", pc_q, crg_pkg::NMI_VECTOR);
        chk("nibble_sp", nibble_sp_q, 16'h00FF);
        for (int s = 0; s < 8; s++) begin
          @(posedge mclk);
          int_en_set <= 1'h1;
          @(posedge mclk);
          int_en_set <= 1'h0;
          take_int(1'h0, s[2:0], 16'h0200 + 16'(s));
          chk("irq pc", pc_q, (s > 5) ? 16'h010E : 16'h0104 + 16'(2 * s));
        end
        $display("test interrupt gate and entry done");
        @(posedge mclk);
        {call_req, call_target, next_pc} <= {1'h1, 16'h4000, 16'h0555};
        @(posedge mclk);
        call_req <= 1'h0;
        exp_wsp = exp_wsp - 10'h004;
        #1 chk("call", {pc_q[14:0], rom_sel}, 16'h8000);
        chk("call push", {push_wide, push_flag, wide_sp_q}, {4'h0, 2'h2, exp_wsp});
        chk("call pc", push_pc_q, 16'h0555);
        @(posedge mclk);
        {prefix_wr, prefix_d} <= {1'h1, 8'hA5};
        @(posedge mclk);
        prefix_wr <= 1'h0;
        {nmi_req, step_done, next_pc} <= {2'h3, 16'h0300};
        #1 chk("prefix", {ext_flag_q, prefix_q}, 16'h01A5);
        chk("take while prefixed", int_take, 16'h0);
        @(posedge mclk);
        {nmi_req, next_pc} <= {1'h0, 16'h0301};
        #1 chk("ext after step", {ext_flag_q, pc_q}, 20'h10300);
        @(posedge mclk);
        {step_done, halt_opcode} <= 2'h1;
        #1 chk("ext cleared", {ext_flag_q, rom_sel}, 16'h1);
        @(posedge mclk);
        halt_opcode <= 1'h0;
        {r_out_wr, r_out_d, r_func_wr, r_func_d} <= {1'h1, 12'h5A3, 1'h1, 12'h00F};
        {p_wr, p_out_d, p_dir_d} <= {1'h1, 16'h00FF, 16'h0F0F};
        #1 chk("halt", {halt_bad_q, pc_q}, 20'h10301);
        @(posedge mclk);
        {r_out_wr, r_func_wr, p_wr} <= 3'h0;
        #1 chk("r_pins", {r_pin_q, r_func_q}, 24'h5A300F);
        chk("p_pins", {p_oe_q, p_out_q, p_pullup}, 48'h0F0F00FFF0F0);
        $display("test call prefix halt pins done");
        @(posedge mclk);
        rst_b <= 1'h0;
      end
    end
    chk("gate after reset", int_gate, 16'h0);
    $display("test second reset done");
    wrap_up();
  end

  // nmi offered with an instruction end must not enter while the gate is shut
  task automatic take_int_blocked;
    @(posedge mclk);
    {nmi_req, step_done, next_pc} <= {2'h3, 16'h0111};
    #1 chk("nmi masked", int_take, 16'h0);
    @(posedge mclk);
    {nmi_req, step_done} <= 2'h0;
  endtask
endmodule
